// File: core/sbrg_pkg.sv
// sbrg_pkg: register map, field positions, reset values and prescale
// figures shared by the rate generator's register front end and its timer.
// assumes a single 40 MHz clock domain and an AXI4-Lite bus of 32 data bits.
package sbrg_pkg;

  // ==========================================================================
  // clock and bus widths
  localparam int unsigned CLK_FREQ_HZ = 40000000;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 10;

  // ==========================================================================
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_RECEIVE_STATUS_CONTROL = 10'h018;
  localparam logic [IDX_W-1:0] IDX_TRANSMIT_STATUS_CONTROL = 10'h098;
  localparam logic [IDX_W-1:0] IDX_BAUD_DIVISOR = 10'h099;
  localparam logic [IDX_W-1:0] IDX_RATE_STATUS = 10'h09A;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_RECEIVE_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h02;
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;

  // ==========================================================================
  // writable bit masks; other bits are read-only or unimplemented
  localparam logic [7:0] TX_WRITE_MASK = 8'hF5;
  localparam logic [7:0] RX_WRITE_MASK = 8'hF8;

  // ==========================================================================
  // field positions in transmit_status_control
  localparam int unsigned BIT_CLOCK_SOURCE_SELECT = 7;
  localparam int unsigned BIT_SYNC_MODE = 4;
  localparam int unsigned BIT_HIGH_SPEED_SELECT = 2;

  // ==========================================================================
  // field positions in rate_status
  localparam int unsigned STAT_TIMER_LSB = 0;
  localparam int unsigned STAT_COUNT_LSB = 8;
  localparam int unsigned STAT_RUNNING_BIT = 16;

  // ==========================================================================
  // oscillator clocks per timer step for each mode
  localparam logic [6:0] PRESC_ASYNC_LOW = 7'h40;
  localparam logic [6:0] PRESC_ASYNC_HIGH = 7'h10;
  localparam logic [6:0] PRESC_SYNC = 7'h04;

  // ==========================================================================
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : sbrg_pkg

// File: core/sbrg_link_if.sv
// sbrg_link_if: settings going from the register front end to the timer,
// and timer state coming back.
// assumes both ends sit on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface sbrg_link_if;
  logic [7:0] divisor;
  logic high_speed_select;
  logic sync_mode;
  logic clock_source_select;
  logic restart;
  logic tick;
  logic [7:0] timer_value;
  logic running;

  modport ctrl (
    output divisor,
    output high_speed_select,
    output sync_mode,
    output clock_source_select,
    output restart,
    input tick,
    input timer_value,
    input running
  );

  modport timer (
    input divisor,
    input high_speed_select,
    input sync_mode,
    input clock_source_select,
    input restart,
    output tick,
    output timer_value,
    output running
  );
endinterface : sbrg_link_if

`default_nettype wire

// File: core/sbrg_timer.sv
// sbrg_timer: prescaler plus free-running 8-bit timer producing the rate tick.
// assumes settings arrive registered and restart is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none

module sbrg_timer
  import sbrg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  sbrg_link_if.timer link
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [6:0] presc;
    logic [7:0] timer;
    logic tick;
    logic running;
  } sbrg_timer_state_t;

  sbrg_timer_state_t s;
  sbrg_timer_state_t next_s;

  function automatic logic [6:0] sbrg_presc_limit(input logic sync_mode, input logic hs);
    logic [6:0] lim;
    if (sync_mode) begin
      lim = PRESC_SYNC;
    end else if (hs) begin
      lim = PRESC_ASYNC_HIGH;
    end else begin
      lim = PRESC_ASYNC_LOW;
    end
    return lim - 7'h01;
  endfunction : sbrg_presc_limit

  // ==========================================================================
  // counting
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    // slave in sync mode: clock comes from outside, so no rate here
    next_s.running = ~(link.sync_mode & ~link.clock_source_select);
    if (link.restart || !next_s.running) begin
      next_s.presc = 7'h00;
      next_s.timer = 8'h00;
    end else if (s.presc >= sbrg_presc_limit(link.sync_mode, link.high_speed_select)) begin
      // >= so a mode change to a shorter prescale never overshoots
      next_s.presc = 7'h00;
      if (s.timer >= link.divisor) begin
        next_s.timer = 8'h00;
        next_s.tick = 1'b1;
      end else begin
        next_s.timer = s.timer + 8'h01;
      end
    end else begin
      next_s.presc = s.presc + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.tick = s.tick;
  assign link.timer_value = s.timer;
  assign link.running = s.running;

endmodule : sbrg_timer

`default_nettype wire

// File: core/sbrg_top.sv
// sbrg_top: AXI4-Lite register front end of the serial rate generator,
// holding the mode and divisor registers and driving the rate tick out.
// assumes one clock, synchronous active-low reset, one write and one read
// under way at a time.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - one generator serves both asynchronous and synchronous port modes
// - free-running 8-bit timer, period set by the divisor register
// - sync mode ignores high-speed select; high speed has no rate there
// - in sync mode rates hold only when the port is clock master; a sync slave stops the generator, async always runs
// - async low speed: rate is clock over 64 times divisor plus one
// - async high speed: rate is clock over 16 times divisor plus one
// - sync mode: rate is clock over 4 times divisor plus one
// - divisor takes any value 0 to 255, each a distinct period
// - writing the divisor clears the timer so the new rate starts at once
// - divisor clears to zero on every reset
module sbrg_top
  import sbrg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic rate_tick
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic [IDX_W-1:0] aw_index;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic [7:0] receive_status_control;
    logic [7:0] transmit_status_control;
    logic [7:0] baud_divisor;
    logic restart;
    logic [7:0] tick_count;
  } sbrg_top_state_t;

  sbrg_top_state_t s;
  sbrg_top_state_t next_s;

  sbrg_link_if link ();

  // ==========================================================================
  // address decode shared by both paths
  function automatic logic sbrg_mapped(input logic [IDX_W-1:0] idx);
    logic hit;
    hit = (idx == IDX_RECEIVE_STATUS_CONTROL) ||
          (idx == IDX_TRANSMIT_STATUS_CONTROL) ||
          (idx == IDX_BAUD_DIVISOR) ||
          (idx == IDX_RATE_STATUS);
    return hit;
  endfunction : sbrg_mapped

  function automatic logic [IDX_W-1:0] sbrg_index(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction : sbrg_index

  function automatic logic [7:0] sbrg_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] mask);
    return (new_v & mask) | (old_v & ~mask);
  endfunction : sbrg_merge

  // ==========================================================================
  // read data for one index
  function automatic logic [DATA_W-1:0] sbrg_read(input sbrg_top_state_t st,
                                                  input logic [IDX_W-1:0] idx,
                                                  input logic [7:0] tval,
                                                  input logic run);
    logic [DATA_W-1:0] d;
    d = '0;
    case (idx)
      IDX_RECEIVE_STATUS_CONTROL: begin
        d[7:0] = st.receive_status_control;
      end
      IDX_TRANSMIT_STATUS_CONTROL: begin
        d[7:0] = st.transmit_status_control;
      end
      IDX_BAUD_DIVISOR: begin
        d[7:0] = st.baud_divisor;
      end
      IDX_RATE_STATUS: begin
        d[STAT_TIMER_LSB +: 8] = tval;
        d[STAT_COUNT_LSB +: 8] = st.tick_count;
        d[STAT_RUNNING_BIT] = run;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction : sbrg_read

  // ==========================================================================
  // bus handling and registers
  always_comb begin
    next_s = s;
    next_s.restart = 1'b0;

    // address and data taken in either order, each held until used
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_index = sbrg_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata[7:0];
      next_s.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bready && s.bvalid) begin
      next_s.bvalid = 1'b0;
    end

    // commit only from held copies, so no input reaches a register path combinationally
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = sbrg_mapped(s.aw_index) ? RESP_OKAY : RESP_SLVERR;
      if (s.w_lane0) begin
        case (s.aw_index)
          IDX_RECEIVE_STATUS_CONTROL: begin
            next_s.receive_status_control = sbrg_merge(s.receive_status_control,
                                                       s.w_data, RX_WRITE_MASK);
          end
          IDX_TRANSMIT_STATUS_CONTROL: begin
            // mode bits steer the timer prescale and enable
            next_s.transmit_status_control = sbrg_merge(s.transmit_status_control,
                                                        s.w_data, TX_WRITE_MASK);
          end
          IDX_BAUD_DIVISOR: begin
            next_s.baud_divisor = s.w_data;
            next_s.restart = 1'b1;
          end
          default: begin
            next_s.restart = 1'b0;
          end
        endcase
      end
    end
    next_s.awready = ~next_s.aw_held;
    next_s.wready = ~next_s.w_held;

    // reads answer one cycle after the address is taken
    if (s_axi_rready && s.rvalid) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = sbrg_read(s, sbrg_index(s_axi_araddr), link.timer_value, link.running);
      next_s.rresp = sbrg_mapped(sbrg_index(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
    end

    // wraps at 255; software reads differences
    if (link.tick) begin
      next_s.tick_count = s.tick_count + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.receive_status_control <= RST_RECEIVE_STATUS_CONTROL;
      s.transmit_status_control <= RST_TRANSMIT_STATUS_CONTROL;
      s.baud_divisor <= RST_BAUD_DIVISOR;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // settings to the timer
  assign link.divisor = s.baud_divisor;
  assign link.high_speed_select = s.transmit_status_control[BIT_HIGH_SPEED_SELECT];
  assign link.sync_mode = s.transmit_status_control[BIT_SYNC_MODE];
  assign link.clock_source_select = s.transmit_status_control[BIT_CLOCK_SOURCE_SELECT];
  assign link.restart = s.restart;

  sbrg_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .link(link.timer)
  );

  // ==========================================================================
  // outputs, all from flip-flops
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign rate_tick = link.tick;

endmodule : sbrg_top

`default_nettype wire

// File: tb/sbrg_props.sv
// sbrg_props: port-level assertions for the rate generator top.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// checker
module sbrg_props
  import sbrg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rate_tick
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // only clean takes; a pending answer delays the commit
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_tick_spacing: assert property (rate_tick |=> !rate_tick [*3])
    else $error("rate tick closer than four cycles");
  a_tick_boot: assert property ($rose(aresetn) |-> !rate_tick [*8])
    else $error("rate tick too soon after reset");
  a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_write_held: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write channels not blocked");
  a_ready_back: assert property (s_wr_take ##2 s_axi_bvalid |-> s_axi_awready)
    else $error("write address ready not back");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_bvalid_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  a_rvalid_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
endmodule : sbrg_props

bind sbrg_top sbrg_props sbrg_props_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .rate_tick);

`default_nettype wire

// File: tb/sbrg_tb_top.sv
// sbrg_tb_top: self-checking bench for the rate generator.
// assumes the top and the checker bind are compiled alongside.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// bench
module sbrg_tb_top;
  import sbrg_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rate_tick;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'hF;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  sbrg_top sbrg_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rate_tick);

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // longest test waits two 4096-cycle periods
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic w(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ad;
    logic wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, e}, "bresp");
  endtask : w

  task automatic r(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] e,
                   input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata & m, ed & m, "rdata");
    chk({30'h0, s_axi_rresp}, {30'h0, e}, "rresp");
  endtask : r

  // cycles between two successive ticks
  task automatic gap(input int exp);
    int n;
    n = 0;
    do @(posedge aclk); while (rate_tick !== 1'h1);
    do begin
      @(posedge aclk);
      n++;
    end while (rate_tick !== 1'h1);
    chk(n, exp, "tick gap");
  endtask : gap

  task automatic t_regs();
    r(12'h268, 32'h10000, RESP_OKAY);
    r(12'h060, 32'h0, RESP_OKAY);
    r(12'h260, 32'h2, RESP_OKAY);
    r(12'h264, 32'h0, RESP_OKAY);
    w(12'h004, 32'hFF, RESP_SLVERR);
    r(12'h004, 32'h0, RESP_SLVERR);
    w(12'h264, 32'h1FF, RESP_OKAY);
    r(12'h264, 32'hFF, RESP_OKAY);
    // lane 0 off: answered but nothing changes
    s_axi_wstrb <= 4'h0;
    w(12'h264, 32'h12, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    r(12'h264, 32'hFF, RESP_OKAY);
    $display("test regs done");
  endtask : t_regs

  task automatic t_rates();
    w(12'h260, 32'h0, RESP_OKAY);
    w(12'h264, 32'h0, RESP_OKAY);
    gap(int'(PRESC_ASYNC_LOW));
    w(12'h264, 32'h3, RESP_OKAY);
    gap(int'(PRESC_ASYNC_LOW) * 4);
    w(12'h260, 32'h4, RESP_OKAY);
    r(12'h260, 32'h6, RESP_OKAY);
    w(12'h264, 32'h2, RESP_OKAY);
    gap(int'(PRESC_ASYNC_HIGH) * 3);
    w(12'h260, 32'h94, RESP_OKAY);
    w(12'h264, 32'h1, RESP_OKAY);
    gap(int'(PRESC_SYNC) * 2);
    $display("test rates done");
  endtask : t_rates

  task automatic t_slave();
    int n;
    n = 0;
    w(12'h260, 32'h14, RESP_OKAY);
    repeat (4) @(posedge aclk);
    repeat (200) begin
      @(posedge aclk);
      if (rate_tick !== 1'h0) n++;
    end
    chk(n, 0, "slave ticks");
    r(12'h268, 32'h0, RESP_OKAY, 32'h100FF);
    $display("test slave done");
  endtask : t_slave

  task automatic t_restart();
    int n;
    n = 0;
    w(12'h260, 32'h0, RESP_OKAY);
    w(12'h264, 32'hFF, RESP_OKAY);
    repeat (100) @(posedge aclk);
    // without a restart the old prescale phase would set the tick early
    w(12'h264, 32'h0, RESP_OKAY);
    do begin
      @(posedge aclk);
      n++;
    end while (rate_tick !== 1'h1);
    chk(n, int'(PRESC_ASYNC_LOW) + 1, "restart");
    w(12'h260, 32'h4, RESP_OKAY);
    w(12'h264, 32'hFF, RESP_OKAY);
    gap(int'(PRESC_ASYNC_HIGH) * 256);
    $display("test restart done");
  endtask : t_restart

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_rates();
    t_slave();
    t_restart();
    report_and_stop();
  end
endmodule : sbrg_tb_top

`default_nettype wire
